// File: design/retimer_lane_control.sv
// Added by the designer: the AHB-Lite register port and the register offsets.
`default_nettype none
module retimer_lane_control (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic chip_enable_pin,
  input wire logic hpd_pin,
  input wire logic swap_polarity_pin,
  input wire logic signal_detect_enable_pin,
  input wire logic bus_enable_pin,
  input wire logic [1:0] addr_select_pins,
  input wire logic [12:0] rate_mbps,
  input wire retimer_lane_control_pkg::lanes_t rx_lanes,
  output retimer_lane_control_pkg::lanes_t tx_lanes,
  output logic tx_oe,
  output logic [15:0] eq_gain,
  output logic retimer_mode,
  output logic power_down,
  output logic rx_power_on,
  output logic clock_ratio_40,
  output logic [8:0] ddc_rate_kbps,
  output logic [6:0] bus_dev_addr
);
  import retimer_lane_control_pkg::*;

  function automatic logic [3:0] swap_map(input logic [3:0] v, input logic sw);
    swap_map = sw ? {v[2], v[3], v[0], v[1]} : v;
  endfunction

  // Pin synchronisers; the clock lane is sampled here too and its rising edges found below
  logic [14:0] meta_ff, sync_ff;
  logic clk_lane_d_ff, hpd_d_ff;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_ff <= '0;
      sync_ff <= '0;
      clk_lane_d_ff <= 1'b0;
      hpd_d_ff <= 1'b0;
    end else begin
      meta_ff <= {chip_enable_pin, hpd_pin, swap_polarity_pin, signal_detect_enable_pin,
                  bus_enable_pin, addr_select_pins, rx_lanes};
      sync_ff <= meta_ff;
      clk_lane_d_ff <= sync_ff[7];
      hpd_d_ff <= sync_ff[13];
    end
  end

  logic ce_s, hpd_s, hpd_rise, clk_edge;
  lanes_t rx_s;
  assign ce_s = sync_ff[14];
  assign hpd_s = sync_ff[13];
  assign rx_s = lanes_t'(sync_ff[7:0]);
  assign hpd_rise = hpd_s & ~hpd_d_ff;
  assign clk_edge = sync_ff[7] & ~clk_lane_d_ff;

  // Bus slave: zero wait states, so the data phase always completes in one cycle
  logic dp_wr_ff, nxt_dp_wr;
  logic [7:0] dp_idx_ff, nxt_dp_idx;
  logic [31:0] hrdata_ff, nxt_hrdata;
  logic [7:0] mode_ff, nxt_mode;
  logic [15:0] eq_ff, nxt_eq;
  logic [15:0] err_cnt_ff [3];
  logic [7:0] eye_ff [3];
  logic sig_valid_ff;
  pwr_state_t pwr_ff, nxt_pwr;
  logic retimer_ff, swap_act, pol_act;
  logic ap_valid, ap_mapped, wr_mode, wr_err;
  logic [7:0] ap_idx;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_ff;
  assign ap_valid = hsel & htrans[1] & hready;
  assign ap_idx = haddr[9:2];
  assign ap_mapped = (haddr[31:10] == 22'h000000) && (haddr[1:0] == 2'h0);
  // Writes are dropped while the chip enable is low
  assign wr_mode = dp_wr_ff & ce_s & (dp_idx_ff == IDX_MODE_CTRL);
  assign wr_err = dp_wr_ff & ce_s & ((dp_idx_ff == IDX_ERR01) || (dp_idx_ff == IDX_ERR2));

  always_comb begin
    nxt_dp_wr = ap_valid & hwrite & ap_mapped;
    nxt_dp_idx = ap_idx;
    nxt_hrdata = hrdata_ff;
    if (ap_valid && !hwrite) begin
      nxt_hrdata = 32'h00000000;
      if (!ap_mapped) begin
        nxt_hrdata = 32'h00000000;
      end else if (ap_idx == IDX_MODE_CTRL) begin
        nxt_hrdata = {24'h000000, mode_ff};
      end else if (ap_idx == IDX_STATUS) begin
        nxt_hrdata = {25'h0000000, pwr_ff, sig_valid_ff, pol_act, swap_act, retimer_ff};
      end else if (ap_idx == IDX_ERR01) begin
        nxt_hrdata = {err_cnt_ff[1], err_cnt_ff[0]};
      end else if (ap_idx == IDX_ERR2) begin
        nxt_hrdata = {16'h0000, err_cnt_ff[2]};
      end else if (ap_idx == IDX_EYE) begin
        nxt_hrdata = {8'h00, eye_ff[2], eye_ff[1], eye_ff[0]};
      end else if (ap_idx == IDX_EQ) begin
        nxt_hrdata = {16'h0000, eq_ff};
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr_ff <= 1'b0;
      dp_idx_ff <= 8'h00;
      hrdata_ff <= 32'h00000000;
    end else begin
      dp_wr_ff <= nxt_dp_wr;
      dp_idx_ff <= nxt_dp_idx;
      hrdata_ff <= nxt_hrdata;
    end
  end

  // Configuration registers; reads have no side effect on any of them
  always_comb begin
    nxt_mode = mode_ff;
    nxt_eq = eq_ff;
    if (hpd_rise) begin
      nxt_mode[MC_RATIO] = 1'b0;
    end
    if (wr_mode) begin
      nxt_mode = hwdata[7:0];
    end
    if (dp_wr_ff && ce_s && dp_idx_ff == IDX_EQ) begin
      nxt_eq = hwdata[15:0];
    end
    if (!ce_s) begin
      nxt_mode = MODE_CTRL_RST;
      nxt_eq = EQ_RST;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_ff <= MODE_CTRL_RST;
      eq_ff <= EQ_RST;
    end else begin
      mode_ff <= nxt_mode;
      eq_ff <= nxt_eq;
    end
  end

  // Mode, crossbar control and power state
  logic pd_req, sdet_en, standby_req, nxt_retimer;
  assign pd_req = ~hpd_s | mode_ff[MC_PDOWN] | ~ce_s;
  assign sdet_en = ce_s & (sync_ff[11] | mode_ff[MC_SIGDET]);
  assign standby_req = sdet_en & ~sig_valid_ff;
  assign swap_act = ce_s & (~sync_ff[12] | mode_ff[MC_SWAP]);
  // Pin polarity request is lost whenever the rate falls to redriver operation
  assign pol_act = retimer_ff & ce_s & (sync_ff[12] | mode_ff[MC_POL]);

  always_comb begin
    nxt_retimer = (rate_mbps >= CROSSOVER_MBPS);
    nxt_pwr = pwr_ff;
    case (pwr_ff)
      PWR_OFF: begin
        if (!pd_req) begin
          nxt_pwr = standby_req ? PWR_STANDBY : PWR_ACTIVE;
        end
      end
      PWR_STANDBY: begin
        if (pd_req) begin
          nxt_pwr = PWR_OFF;
        end else if (!standby_req) begin
          nxt_pwr = PWR_ACTIVE;
        end
      end
      PWR_ACTIVE: begin
        if (pd_req) begin
          nxt_pwr = PWR_OFF;
        end else if (standby_req) begin
          nxt_pwr = PWR_STANDBY;
        end
      end
      default: begin
        nxt_pwr = PWR_OFF;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      retimer_ff <= 1'b0;
      pwr_ff <= PWR_OFF;
    end else begin
      retimer_ff <= nxt_retimer;
      pwr_ff <= nxt_pwr;
    end
  end

  // Lane path, PRBS generator, error checkers, eye sampler
  lanes_t tx_ff, nxt_tx, routed;
  logic [6:0] prbs_ff, nxt_prbs;
  logic [6:0] chk_ff [3];
  logic [6:0] nxt_chk [3];
  logic [15:0] nxt_err [3];
  logic [7:0] nxt_eye [3];
  logic [7:0] idle_ff, nxt_idle;
  logic nxt_sig_valid, exp_bit;

  always_comb begin
    routed.p = swap_map(rx_s.p, swap_act);
    routed.n = swap_map(rx_s.n, swap_act);
    nxt_tx = routed;
    if (pol_act) begin
      nxt_tx.p = routed.n;
      nxt_tx.n = routed.p;
    end
    nxt_prbs = prbs_ff;
    if (clk_edge) begin
      nxt_prbs = {prbs_ff[5:0], prbs_ff[6] ^ prbs_ff[5]};
    end
    if (mode_ff[MC_PRBS]) begin
      // Output rate follows the clock applied on the input clock lane
      nxt_tx.p[2:0] = {3{prbs_ff[6]}};
      nxt_tx.n[2:0] = {3{~prbs_ff[6]}};
    end
    nxt_idle = clk_edge ? 8'h00 : idle_ff;
    if (!clk_edge && idle_ff != SIG_TIMEOUT_CYC) begin
      nxt_idle = idle_ff + 8'h01;
    end
    nxt_sig_valid = (nxt_idle != SIG_TIMEOUT_CYC);
    exp_bit = 1'b0;
    for (int i = 0; i < 3; i++) begin
      nxt_chk[i] = chk_ff[i];
      nxt_err[i] = wr_err ? 16'h0000 : err_cnt_ff[i];
      nxt_eye[i] = {eye_ff[i][6:0], nxt_tx.p[i]};
      if (clk_edge && mode_ff[MC_CHECK]) begin
        exp_bit = chk_ff[i][6] ^ chk_ff[i][5];
        nxt_chk[i] = {chk_ff[i][5:0], nxt_tx.p[i]};
        // Self-synchronising checker: counts are approximate after a slip
        if (exp_bit != nxt_tx.p[i] && err_cnt_ff[i] != 16'hFFFF) begin
          nxt_err[i] = err_cnt_ff[i] + 16'h0001;
        end
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_ff <= '0;
      prbs_ff <= PRBS_SEED;
      idle_ff <= 8'h00;
      sig_valid_ff <= 1'b0;
      for (int i = 0; i < 3; i++) begin
        chk_ff[i] <= 7'h00;
        err_cnt_ff[i] <= 16'h0000;
        eye_ff[i] <= 8'h00;
      end
    end else begin
      tx_ff <= nxt_tx;
      prbs_ff <= nxt_prbs;
      idle_ff <= nxt_idle;
      sig_valid_ff <= nxt_sig_valid;
      for (int i = 0; i < 3; i++) begin
        chk_ff[i] <= nxt_chk[i];
        err_cnt_ff[i] <= nxt_err[i];
        eye_ff[i] <= nxt_eye[i];
      end
    end
  end

  // Registered side outputs
  logic [15:0] eq_ff2, nxt_eq_out;
  logic [8:0] ddc_ff, nxt_ddc;
  logic [6:0] dev_addr_ff, nxt_dev_addr;
  logic ratio_ff, nxt_ratio;
  always_comb begin
    // Equalizer gain per physical input pin, following the channel it now feeds
    nxt_eq_out = swap_act ? {eq_ff[11:8], eq_ff[15:12], eq_ff[3:0], eq_ff[7:4]} : eq_ff;
    nxt_ddc = mode_ff[MC_DDC_FAST] ? DDC_FAST_KBPS : DDC_SLOW_KBPS;
    nxt_dev_addr = {BUS_ADDR_BASE, (ce_s & sync_ff[10]) ? sync_ff[9:8] : 2'h0};
    nxt_ratio = mode_ff[MC_RATIO] & (pwr_ff != PWR_OFF);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      eq_ff2 <= EQ_RST;
      ddc_ff <= DDC_SLOW_KBPS;
      dev_addr_ff <= {BUS_ADDR_BASE, 2'h0};
      ratio_ff <= 1'b0;
    end else begin
      eq_ff2 <= nxt_eq_out;
      ddc_ff <= nxt_ddc;
      dev_addr_ff <= nxt_dev_addr;
      ratio_ff <= nxt_ratio;
    end
  end

  assign tx_lanes = tx_ff;
  assign tx_oe = (pwr_ff == PWR_ACTIVE);
  assign eq_gain = eq_ff2;
  assign retimer_mode = retimer_ff;
  assign power_down = (pwr_ff == PWR_OFF);
  assign rx_power_on = (pwr_ff == PWR_ACTIVE);
  assign clock_ratio_40 = ratio_ff;
  assign ddc_rate_kbps = ddc_ff;
  assign bus_dev_addr = dev_addr_ff;

  property p_crossover;
    @(posedge hclk) disable iff (!hresetn) 1'b1 |=> retimer_ff == ($past(rate_mbps) >= 13'h3E8);
  endproperty
  a_crossover: assert property (p_crossover) else $error("mode does not follow rate");

  property p_pdown;
    @(posedge hclk) disable iff (!hresetn) (mode_ff[MC_PDOWN] || !hpd_s) |=> power_down;
  endproperty
  a_pdown: assert property (p_pdown) else $error("power-down not entered");

  property p_ce_clear;
    @(posedge hclk) disable iff (!hresetn) !ce_s |=> (mode_ff == 8'h00) && (eq_ff == 16'h0000);
  endproperty
  a_ce_clear: assert property (p_ce_clear) else $error("registers kept through chip disable");

  property p_ratio_wake;
    @(posedge hclk) disable iff (!hresetn) (hpd_rise && !wr_mode) |=> !mode_ff[MC_RATIO] ##1 !clock_ratio_40;
  endproperty
  a_ratio_wake: assert property (p_ratio_wake) else $error("ratio flag kept after wake");

  property p_ratio_keep;
    @(posedge hclk) disable iff (!hresetn)
      (mode_ff[MC_RATIO] && ce_s && !hpd_rise && !wr_mode) |=> mode_ff[MC_RATIO];
  endproperty
  a_ratio_keep: assert property (p_ratio_keep) else $error("ratio flag lost without cause");

  property p_standby;
    @(posedge hclk) disable iff (!hresetn) (sdet_en && !sig_valid_ff) |=> !rx_power_on;
  endproperty
  a_standby: assert property (p_standby) else $error("receiver on without signal");

  property p_swap_route;
    @(posedge hclk) disable iff (!hresetn)
      (swap_act && !pol_act && !mode_ff[MC_PRBS]) |=> tx_ff.p[3] == $past(rx_s.p[2]);
  endproperty
  a_swap_route: assert property (p_swap_route) else $error("lane two not on clock output");

  property p_pol_retimer;
    @(posedge hclk) disable iff (!hresetn) !retimer_ff |-> !pol_act;
  endproperty
  a_pol_retimer: assert property (p_pol_retimer) else $error("polarity in redriver mode");

  property p_ce_hiz;
    @(posedge hclk) disable iff (!hresetn) !ce_s |=> !tx_oe && power_down;
  endproperty
  a_ce_hiz: assert property (p_ce_hiz) else $error("outputs driven while disabled");
endmodule
`default_nettype wire

// File: design/retimer_lane_control_pkg.sv
// What this block does
// - Redriver below 1.0 Gbps data rate, retimer at or above it.
// - Power down on low hot-plug, control bit 3 set, or chip enable low.
// - Chip enable low clears control and equalizer registers; controller reprograms after re-enable.
// - After wake, source must set clock ratio flag before 1/40 clock mode resumes.
// - No read clears the clock ratio flag.
// - Detection on: standby without valid input; detection off: receiver stays powered.
// - Control channel bridge runs at 100 kbps, software may raise it to 400.
// - Bus enable set: bus address low bits come from address select pins.
// - Chip enable low: control inputs ignored, video outputs high impedance.
// - Swap: in2 to clock out, in1 to out0, in0 to out1, clock in to out2.
// - Swap active when swap pin low or control bit 7 set.
// - Equalizer settings follow the swapped lane assignment.
// - Lane swap works in both redriver and retimer operation.
// - Swap/polarity pin high exchanges positive and negative of every input lane.
// - Polarity inversion applies only in retimer operation.
// - Swap and polarity inversion may be active together in retimer operation.
// - Polarity inversion also selectable by a bus register.
// - Pattern checker counts bit errors separately on each of three data lanes.
// - Per-lane eye sample data readable over the register bus.
// - PRBS generator drives data outputs, clocked by the input clock lane.
// - Signal detection disabled after reset until pin or register enables it.
`default_nettype none
package retimer_lane_control_pkg;
  localparam logic [7:0] IDX_MODE_CTRL = 8'h09;
  localparam logic [7:0] IDX_STATUS = 8'h10;
  localparam logic [7:0] IDX_ERR01 = 8'h11;
  localparam logic [7:0] IDX_ERR2 = 8'h12;
  localparam logic [7:0] IDX_EYE = 8'h13;
  localparam logic [7:0] IDX_EQ = 8'h14;
  localparam int MC_SIGDET = 0;
  localparam int MC_DDC_FAST = 1;
  localparam int MC_POL = 2;
  localparam int MC_PDOWN = 3;
  localparam int MC_PRBS = 4;
  localparam int MC_CHECK = 5;
  localparam int MC_RATIO = 6;
  localparam int MC_SWAP = 7;
  localparam logic [7:0] MODE_CTRL_RST = 8'h00;
  localparam logic [15:0] EQ_RST = 16'h0000;
  localparam logic [6:0] PRBS_SEED = 7'h7F;
  localparam logic [12:0] CROSSOVER_MBPS = 13'h3E8;
  localparam logic [8:0] DDC_SLOW_KBPS = 9'h064;
  localparam logic [8:0] DDC_FAST_KBPS = 9'h190;
  localparam logic [4:0] BUS_ADDR_BASE = 5'h0B;
  localparam int CLK_PERIOD_NS = 4;
  localparam int SIG_TIMEOUT_NS = 256;
  localparam logic [7:0] SIG_TIMEOUT_CYC = 8'(SIG_TIMEOUT_NS / CLK_PERIOD_NS);
  typedef struct packed {
    logic [3:0] p;
    logic [3:0] n;
  } lanes_t;
  typedef enum logic [2:0] {
    PWR_OFF = 3'b001,
    PWR_STANDBY = 3'b010,
    PWR_ACTIVE = 3'b100
  } pwr_state_t;
endpackage
`default_nettype wire

// File: tb/video_source.sv
`default_nettype none
module video_source (
  input wire logic run,
  input wire logic [2:0] data,
  output retimer_lane_control_pkg::lanes_t lanes
);
  timeunit 1ns;
  timeprecision 100ps;
  import retimer_lane_control_pkg::*;
  logic clk_lane = 1'b0;
  // Clock lane stands still low between frames, it does not run free
  always begin
    #16;
    clk_lane = run ? ~clk_lane : 1'b0;
  end
  assign lanes = '{p: {clk_lane, data}, n: ~{clk_lane, data}};
endmodule
`default_nettype wire

// File: tb/testbench.sv
`default_nettype none
`define CHK(a, e, m) begin checks++; if ((a) !== (e)) begin n_mismatch++; \
  $display("[FAIL] %0t %s", $time, m); end end
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import retimer_lane_control_pkg::*;
  logic hclk, hresetn, hsel, hwrite, ce, hpd, swp, sde, ben, run;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0] htrans, asel;
  logic [2:0] hsize, dat;
  logic [12:0] rate;
  logic hready, hresp, tx_oe, retimer_mode, power_down, rx_power_on, clock_ratio_40;
  logic [15:0] eq_gain;
  logic [8:0] ddc_rate_kbps;
  logic [6:0] bus_dev_addr;
  lanes_t rx, tx;
  int n_mismatch = 0;
  int checks = 0;

  retimer_lane_control DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .chip_enable_pin(ce),
    .hpd_pin(hpd), .swap_polarity_pin(swp), .signal_detect_enable_pin(sde),
    .bus_enable_pin(ben), .addr_select_pins(asel), .rate_mbps(rate), .rx_lanes(rx),
    .tx_lanes(tx), .tx_oe(tx_oe), .eq_gain(eq_gain), .retimer_mode(retimer_mode),
    .power_down(power_down), .rx_power_on(rx_power_on), .clock_ratio_40(clock_ratio_40),
    .ddc_rate_kbps(ddc_rate_kbps), .bus_dev_addr(bus_dev_addr));
  video_source src (.run(run), .data(dat), .lanes(rx));

  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end

  function automatic lanes_t route(lanes_t i, logic sw, logic pol);
    lanes_t o;
    o = i;
    if (sw) begin
      o.p = {i.p[2], i.p[3], i.p[0], i.p[1]};
      o.n = {i.n[2], i.n[3], i.n[0], i.n[1]};
    end
    if (pol) o = '{p: o.n, n: o.p};
    return o;
  endfunction

  task automatic xfer(input logic w, input logic [7:0] idx, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {22'h0, idx, 2'h0};
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    q = hrdata;
    `CHK(hresp, 1'b0, "error response on bus")
  endtask

  task automatic st;
    repeat (8) @(posedge hclk);
  endtask

  task automatic ce_cycle(input logic [31:0] v);
    @(posedge hclk);
    ce <= 1'b0;
    st;
    `CHK(tx_oe, 1'b0, "outputs live while disabled")
    `CHK(power_down, 1'b1, "no power-down while disabled")
    xfer(1'b1, IDX_MODE_CTRL, v);
    // Full reset needs the enable held low for 100 us
    repeat (25000) @(posedge hclk);
    ce <= 1'b1;
    st;
  endtask

  task automatic t_reset;
    `CHK(power_down, 1'b1, "powered while disabled")
    `CHK(ddc_rate_kbps, DDC_SLOW_KBPS, "bridge rate after reset")
    ce_cycle(32'h0);
    `CHK(power_down, 1'b0, "stuck in power-down")
    `CHK(rx_power_on, 1'b1, "receiver off with detection off")
    xfer(1'b0, IDX_MODE_CTRL, 32'h0);
    `CHK(q, 32'h0, "control reset value")
  endtask

  task automatic t_power;
    xfer(1'b1, IDX_MODE_CTRL, 32'h8);
    st;
    `CHK(power_down, 1'b1, "bit 3 ignored")
    xfer(1'b1, IDX_MODE_CTRL, 32'h0);
    st;
    `CHK(power_down, 1'b0, "bit 3 clear ignored")
    hpd <= 1'b0;
    st;
    `CHK(power_down, 1'b1, "hot-plug low ignored")
    hpd <= 1'b1;
    st;
    `CHK(power_down, 1'b0, "no wake on hot-plug")
  endtask

  task automatic t_route;
    for (int k = 0; k < 4; k++) begin
      rate <= k[0] ? 13'h3E8 : 13'h3E7;
      swp <= k[1];
      st;
      `CHK(retimer_mode, k[0], "crossover wrong")
      `CHK(tx, route(rx, ~k[1], k[1] & k[0]), "lane routing")
    end
  endtask

  task automatic t_regs;
    swp <= 1'b0;
    xfer(1'b1, IDX_MODE_CTRL, 32'h4);
    st;
    `CHK(tx, route(rx, 1'b1, 1'b1), "swap with register polarity")
    xfer(1'b0, IDX_STATUS, 32'h0);
    `CHK(q[2:0], 3'h7, "status mode bits")
    swp <= 1'b1;
    xfer(1'b1, IDX_MODE_CTRL, 32'h80);
    xfer(1'b1, IDX_EQ, 32'h4321);
    st;
    `CHK(tx, route(rx, 1'b1, 1'b1), "register swap")
    `CHK(eq_gain, 16'h3412, "equalizer mapping")
    xfer(1'b1, IDX_MODE_CTRL, 32'h2);
    ben <= 1'b1;
    asel <= 2'h2;
    st;
    `CHK(ddc_rate_kbps, DDC_FAST_KBPS, "fast bridge rate")
    `CHK(bus_dev_addr, {BUS_ADDR_BASE, 2'h2}, "bus address")
    xfer(1'b0, 8'h3F, 32'h0);
    `CHK(q, 32'h0, "unmapped read")
  endtask

  task automatic t_ratio;
    xfer(1'b1, IDX_MODE_CTRL, 32'h40);
    st;
    `CHK(clock_ratio_40, 1'b1, "ratio mode not entered")
    xfer(1'b0, IDX_MODE_CTRL, 32'h0);
    st;
    `CHK(q[6], 1'b1, "flag lost on read")
    `CHK(clock_ratio_40, 1'b1, "ratio dropped by read")
    hpd <= 1'b0;
    st;
    hpd <= 1'b1;
    st;
    `CHK(clock_ratio_40, 1'b0, "ratio kept after wake")
    // The source rewrites the flag after wake to get the ratio mode back
    xfer(1'b1, IDX_MODE_CTRL, 32'h40);
    st;
    `CHK(clock_ratio_40, 1'b1, "ratio not resumed by rewrite")
  endtask

  task automatic t_sigdet;
    xfer(1'b1, IDX_MODE_CTRL, 32'h1);
    st;
    `CHK(rx_power_on, 1'b0, "no standby without signal")
    `CHK(tx_oe, 1'b0, "outputs live in standby")
    run <= 1'b1;
    repeat (40) @(posedge hclk);
    `CHK(rx_power_on, 1'b1, "no wake on signal")
    run <= 1'b0;
    repeat (100) @(posedge hclk);
    `CHK(rx_power_on, 1'b0, "no standby after signal loss")
    sde <= 1'b1;
    xfer(1'b1, IDX_MODE_CTRL, 32'h0);
    st;
    `CHK(rx_power_on, 1'b0, "pin enable ignored")
    sde <= 1'b0;
    st;
    `CHK(rx_power_on, 1'b1, "receiver off with detection off")
  endtask

  task automatic t_prbs;
    logic [1:0] seen;
    seen = 2'h0;
    rate <= 13'h3E7;
    xfer(1'b1, IDX_MODE_CTRL, 32'h30);
    // The generator's output rate comes from the clock put on the input clock lane
    run <= 1'b1;
    repeat (200) @(posedge hclk);
    xfer(1'b1, IDX_ERR01, 32'h0);
    for (int k = 0; k < 16; k++) begin
      repeat (8) @(posedge hclk);
      seen = seen | {tx.p[0], ~tx.p[0]};
      `CHK({tx.p[2:0], tx.n[2:0]}, {{3{tx.p[0]}}, {3{~tx.p[0]}}}, "generator lanes")
    end
    `CHK(seen, 2'h3, "generator output stuck")
    xfer(1'b0, IDX_ERR01, 32'h0);
    `CHK(q, 32'h0, "errors on clean pattern")
    xfer(1'b0, IDX_ERR2, 32'h0);
    `CHK(q, 32'h0, "errors on clean pattern lane two")
    // Static data: lanes zero and two stuck high break the pattern, lane one stuck low does not
    xfer(1'b1, IDX_MODE_CTRL, 32'h20);
    repeat (80) @(posedge hclk);
    xfer(1'b1, IDX_ERR2, 32'h0);
    repeat (100) @(posedge hclk);
    xfer(1'b0, IDX_ERR01, 32'h0);
    `CHK({q[31:16] == 16'h0, q[15:0] != 16'h0}, 2'h3, "lane errors not separate")
    xfer(1'b0, IDX_ERR2, 32'h0);
    `CHK(q[15:0] != 16'h0, 1'b1, "lane two errors missing")
    xfer(1'b0, IDX_EYE, 32'h0);
    `CHK(q, 32'h00FF00FF, "eye samples")
    run <= 1'b0;
  endtask

  task automatic t_ce;
    xfer(1'b1, IDX_MODE_CTRL, 32'h82);
    ce_cycle(32'h80);
    xfer(1'b0, IDX_MODE_CTRL, 32'h0);
    `CHK(q, 32'h0, "registers survive chip enable")
    `CHK(ddc_rate_kbps, DDC_SLOW_KBPS, "bridge rate survives")
  endtask

  task automatic report_and_stop;
    $display("checks=%0d mismatches=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    #300000;
    n_mismatch++;
    report_and_stop;
  end

  initial begin
    {hresetn, hsel, hwrite, ce, sde, ben, run} = '0;
    {hpd, swp} = 2'h3;
    {haddr, hwdata, htrans, asel} = '0;
    hsize = 3'h2;
    rate = 13'h3E7;
    dat = 3'h5;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset;
    t_power;
    t_route;
    t_regs;
    t_ratio;
    t_sigdet;
    t_prbs;
    t_ce;
    report_and_stop;
  end
endmodule
`default_nettype wire
